// file: hdl/deep_sleep_clock_control.sv
`timescale 1ns/10ps
module deep_sleep_clock_control #(
    parameter int                            SETTLE_CYCLES = sleep_ctl_pkg::SETTLE_CYCLES_DEF,
    parameter int                            CACHE_DIVIDE  = sleep_ctl_pkg::CACHE_DIVIDE_DEF,
    parameter logic [sleep_ctl_pkg::VSEL_WIDTH-1:0] VSEL_CODE = sleep_ctl_pkg::VSEL_DEF
) (
    input  wire logic                                   clock,
    input  wire logic                                   rst,
    input  wire logic                                   bus_clock_running,
    input  wire logic                                   stop_clock_request_n,
    input  wire logic                                   sleep_request_n,
    input  wire logic                                   halt_request,
    input  wire logic                                   interrupt_in,
    input  wire logic                                   snoop_request,
    input  wire logic                                   snoop_done,
    output sleep_ctl_pkg::power_state_type              power_state,
    output logic                                        cache_clock,
    output logic                                        cache_clock_enable,
    output logic                                        snoop_enable,
    output logic                                        interrupt_take,
    output logic                                        intc_clock_may_stop,
    output logic                                        bus_quiet_violation,
    output logic [sleep_ctl_pkg::VSEL_WIDTH-1:0]        voltage_select_code
);
    import sleep_ctl_pkg::*;

    power_state_type state_q;
    power_state_type state_d;
    logic            return_halt_q;
    logic            interrupt_pending_q;
    logic            interrupt_pending_d;
    logic            interrupt_take_d;
    logic            settle_start;
    logic            settle_abort;
    logic            settle_done;
    logic            cache_run;
    logic            cache_tick;
    logic            stop_clock_active;
    logic            sleep_active;
    logic            asleep;
    logic            interrupt_open;

    // Stop-clock and sleep request pins are active low
    assign stop_clock_active = !stop_clock_request_n;
    assign sleep_active      = !sleep_request_n;

    // States in which the device is blind to the bus
    assign asleep = (state_q == st_sleep) || (state_q == st_deep_sleep)
                 || (state_q == st_settle);

    // Interrupts are latched only outside sleep
    assign interrupt_open = !asleep;

    // Power state sequencer, next-state logic
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_normal: begin
                if (stop_clock_active) begin
                    state_d = st_stop_grant;
                end else if (halt_request) begin
                    state_d = st_auto_halt;
                end
            end
            st_auto_halt: begin
                // Sleep request is not looked at here
                if (stop_clock_active) begin
                    state_d = st_stop_grant;
                end else if (snoop_request) begin
                    state_d = st_halt_snoop;
                end else if (interrupt_in) begin
                    state_d = st_normal;
                end
            end
            st_stop_grant: begin
                if (!stop_clock_active) begin
                    state_d = return_halt_q ? st_auto_halt : st_normal;
                end else if (sleep_active) begin
                    state_d = st_sleep;
                end else if (snoop_request) begin
                    state_d = st_halt_snoop;
                end
            end
            st_halt_snoop: begin
                // Stay until the snoop is serviced, then go back
                if (snoop_done) begin
                    if (stop_clock_active) begin
                        state_d = st_stop_grant;
                    end else begin
                        state_d = return_halt_q ? st_auto_halt : st_normal;
                    end
                end
            end
            st_sleep: begin
                if (!bus_clock_running) begin
                    state_d = st_deep_sleep;
                end else if (!sleep_active) begin
                    state_d = st_stop_grant;
                end
            end
            st_deep_sleep: begin
                // Restarted bus clock begins the settling wait
                if (bus_clock_running) begin
                    state_d = st_settle;
                end
            end
            st_settle: begin
                if (!bus_clock_running) begin
                    state_d = st_deep_sleep;
                end else if (settle_done) begin
                    state_d = st_sleep;
                end
            end
            default: begin
                state_d = st_normal;
            end
        endcase
    end

    // Power state register, one update per rising edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= st_normal;
        end else begin
            state_q <= state_d;
        end
    end

    // Remembers whether stop-grant or a snoop was entered from auto-halt
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            return_halt_q <= FLAG_CLEAR;
        end else if (state_q == st_normal) begin
            return_halt_q <= FLAG_CLEAR;
        end else if (state_q == st_auto_halt) begin
            return_halt_q <= FLAG_SET;
        end
    end

    // Settling timer control
    assign settle_start = (state_q == st_deep_sleep) && bus_clock_running;
    assign settle_abort = (state_q == st_settle) && !bus_clock_running;

    settle_timer #(
        .CYCLES (SETTLE_CYCLES),
        .WIDTH  (SETTLE_COUNT_WIDTH)
    ) u_settle (
        .clock  (clock),
        .rst    (rst),
        .start  (settle_start),
        .abort  (settle_abort),
        .done   (settle_done)
    );

    // Cache clock runs everywhere but deep sleep and the settling wait
    assign cache_run = (state_d != st_deep_sleep) && (state_d != st_settle);

    rate_divider #(
        .DIVIDE (CACHE_DIVIDE),
        .WIDTH  (DIVIDE_COUNT_WIDTH)
    ) u_cache_div (
        .clock  (clock),
        .rst    (rst),
        .run    (cache_run),
        .tick   (cache_tick)
    );

    // Cache clock output toggles on each divider tick, parks low when stopped
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cache_clock <= FLAG_CLEAR;
        end else if (!cache_run) begin
            cache_clock <= FLAG_CLEAR;
        end else if (cache_tick) begin
            cache_clock <= !cache_clock;
        end
    end

    // Level showing the cache clock is allowed to run
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cache_clock_enable <= FLAG_SET;
        end else begin
            cache_clock_enable <= cache_run;
        end
    end

    // Snoop response gate: open while awake, closed in sleep states
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            snoop_enable <= FLAG_SET;
        end else begin
            case (state_d)
                st_normal,
                st_auto_halt,
                st_stop_grant,
                st_halt_snoop: snoop_enable <= FLAG_SET;
                default:       snoop_enable <= FLAG_CLEAR;
            endcase
        end
    end

    // Interrupt latch: a new event wins over the clear in the same cycle
    always_comb begin
        interrupt_take_d    = (state_q == st_normal) && interrupt_pending_q && !interrupt_take;
        interrupt_pending_d = interrupt_pending_q && !interrupt_take_d;
        if (interrupt_open && interrupt_in) begin
            interrupt_pending_d = FLAG_SET;
        end
    end

    // Pending interrupt held until normal operation takes it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_pending_q <= FLAG_CLEAR;
        end else begin
            interrupt_pending_q <= interrupt_pending_d;
        end
    end

    // One-cycle service pulse, only in normal state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_take <= FLAG_CLEAR;
        end else begin
            interrupt_take <= interrupt_take_d;
        end
    end

    // Tells the far side when its interrupt-controller clock may be removed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            intc_clock_may_stop <= FLAG_CLEAR;
        end else begin
            intc_clock_may_stop <= (state_d == st_sleep)
                                || (state_d == st_deep_sleep);
        end
    end

    // Sticky flag for bus activity while the device is blind to it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bus_quiet_violation <= FLAG_CLEAR;
        end else if (state_q == st_normal) begin
            bus_quiet_violation <= FLAG_CLEAR;
        end else if (asleep && (snoop_request || interrupt_in)) begin
            bus_quiet_violation <= FLAG_SET;
        end
    end

    // Static voltage-select strap
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            voltage_select_code <= VSEL_CODE;
        end else begin
            voltage_select_code <= VSEL_CODE;
        end
    end

    // State register drives the state output directly
    assign power_state = state_q;

endmodule

// file: hdl/sleep_ctl_pkg.sv
package sleep_ctl_pkg;

    // Power states of the clock-stop sequencer
    typedef enum logic [2:0] {
        st_normal,
        st_auto_halt,
        st_stop_grant,
        st_halt_snoop,
        st_sleep,
        st_deep_sleep,
        st_settle
    } power_state_type;

    // Clock rate and loop settling wait
    localparam int CLOCK_KHZ           = 25000;
    localparam int SETTLE_TIME_US      = 1000;
    localparam int SETTLE_CYCLES_DEF   = (SETTLE_TIME_US * CLOCK_KHZ + 999) / 1000;
    localparam int SETTLE_COUNT_WIDTH  = 16;

    // Cache clock divider: enable pulse every this many cycles
    localparam int CACHE_DIVIDE_DEF    = 2;
    localparam int DIVIDE_COUNT_WIDTH  = 8;

    // Voltage-select code width and strap default (1 = open, 0 = grounded)
    localparam int VSEL_WIDTH          = 5;
    localparam logic [4:0] VSEL_DEF    = 5'h0f;

    // Reset values
    localparam logic       FLAG_CLEAR  = 1'b0;
    localparam logic       FLAG_SET    = 1'b1;

endpackage

// file: hdl/settle_timer.sv
`timescale 1ns/10ps
module settle_timer #(
    parameter int CYCLES = sleep_ctl_pkg::SETTLE_CYCLES_DEF,
    parameter int WIDTH  = sleep_ctl_pkg::SETTLE_COUNT_WIDTH
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic abort,
    output logic      done
);
    import sleep_ctl_pkg::*;

    localparam logic [WIDTH-1:0] LOAD_VALUE = WIDTH'(CYCLES - 1);
    localparam logic [WIDTH-1:0] ZERO       = '0;

    logic [WIDTH-1:0] count_q;
    logic             busy_q;

    // Down counter, loaded on start, cleared on abort
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= ZERO;
            busy_q  <= FLAG_CLEAR;
        end else if (abort) begin
            count_q <= ZERO;
            busy_q  <= FLAG_CLEAR;
        end else if (start) begin
            count_q <= LOAD_VALUE;
            busy_q  <= FLAG_SET;
        end else if (busy_q && count_q == ZERO) begin
            busy_q  <= FLAG_CLEAR;
        end else if (busy_q) begin
            count_q <= count_q - WIDTH'(1);
        end
    end

    // One-cycle pulse when the wait has run out
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done <= FLAG_CLEAR;
        end else begin
            done <= busy_q && count_q == ZERO && !abort && !start;
        end
    end
endmodule

// file: hdl/rate_divider.sv
`timescale 1ns/10ps
module rate_divider #(
    parameter int DIVIDE = sleep_ctl_pkg::CACHE_DIVIDE_DEF,
    parameter int WIDTH  = sleep_ctl_pkg::DIVIDE_COUNT_WIDTH
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);
    import sleep_ctl_pkg::*;

    localparam logic [WIDTH-1:0] LAST = WIDTH'(DIVIDE - 1);
    localparam logic [WIDTH-1:0] ZERO = '0;

    logic [WIDTH-1:0] count_q;

    // Free count while running, held at zero when stopped
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= ZERO;
            tick    <= FLAG_CLEAR;
        end else if (!run) begin
            count_q <= ZERO;
            tick    <= FLAG_CLEAR;
        end else if (count_q == LAST) begin
            count_q <= ZERO;
            tick    <= FLAG_SET;
        end else begin
            count_q <= count_q + WIDTH'(1);
            tick    <= FLAG_CLEAR;
        end
    end
endmodule

// file: tb/deep_sleep_clock_control_sva.sv
`timescale 1ns/10ps
module deep_sleep_clock_control_sva #(
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic                          clock,
    input wire logic                          rst,
    input wire logic                          bus_clock_running,
    input wire logic                          stop_clock_request_n,
    input wire logic                          sleep_request_n,
    input wire logic                          snoop_request,
    input wire logic                          snoop_done,
    input wire sleep_ctl_pkg::power_state_type power_state,
    input wire logic                          cache_clock,
    input wire logic                          cache_clock_enable,
    input wire logic                          snoop_enable,
    input wire logic                          interrupt_take
);
    import sleep_ctl_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    int settle_q;
    // Edges spent settling
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            settle_q <= 0;
        end else begin
            settle_q <= (power_state == st_settle) ? settle_q + 1 : 0;
        end
    end
    property p_deep_entry;
        power_state == st_sleep && !bus_clock_running |=> power_state == st_deep_sleep;
    endproperty
    a_deep_entry: assert property (p_deep_entry) else $error("no deep sleep on stopped clock");
    property p_settle_wait;
        power_state == st_settle && settle_q < SETTLE_CYCLES |=> power_state != st_sleep;
    endproperty
    a_settle_wait: assert property (p_settle_wait) else $error("sleep before settling");
    property p_settle_end;
        power_state == st_settle && bus_clock_running && settle_q == SETTLE_CYCLES |=> power_state == st_sleep && cache_clock_enable;
    endproperty
    a_settle_end: assert property (p_settle_end) else $error("no sleep after settling");
    property p_cache_stop;
        power_state inside {st_deep_sleep, st_settle} |-> !cache_clock_enable && !cache_clock;
    endproperty
    a_cache_stop: assert property (p_cache_stop) else $error("cache clock runs in deep sleep");
    property p_cache_tick;
        cache_clock_enable [*6] |-> cache_clock != $past(cache_clock, 2);
    endproperty
    a_cache_tick: assert property (p_cache_tick) else $error("cache clock not toggling");
    property p_block;
        power_state inside {st_sleep, st_deep_sleep, st_settle} |-> !snoop_enable && !interrupt_take;
    endproperty
    a_block: assert property (p_block) else $error("snoop or interrupt while asleep");
    property p_snoop_in;
        power_state == st_stop_grant && !stop_clock_request_n && sleep_request_n && snoop_request |=> power_state == st_halt_snoop && snoop_enable;
    endproperty
    a_snoop_in: assert property (p_snoop_in) else $error("snoop not served");
    property p_snoop_hold;
        power_state == st_halt_snoop && !snoop_done |=> power_state == st_halt_snoop;
    endproperty
    a_snoop_hold: assert property (p_snoop_hold) else $error("snoop service left early");
    property p_grant;
        power_state == st_normal && !stop_clock_request_n |=> power_state == st_stop_grant;
    endproperty
    a_grant: assert property (p_grant) else $error("stop-grant not entered");
    c_deep: cover property (power_state == st_deep_sleep);
    c_wake: cover property (power_state == st_settle ##1 power_state == st_sleep);
    c_snoop: cover property (power_state == st_halt_snoop ##1 power_state == st_auto_halt);
endmodule

// file: tb/system_logic_model.sv
`timescale 1ns/10ps
module system_logic_model (
    input  wire logic clock,
    output logic      bus_clock_running,
    output logic      stop_clock_request_n,
    output logic      sleep_request_n,
    output logic      snoop_request,
    output logic      snoop_done
);
    // Idle: bus clock running, nothing requested
    initial begin
        bus_clock_running = 1'b1;
        stop_clock_request_n = 1'b1;
        sleep_request_n = 1'b1;
        snoop_request = 1'b0;
        snoop_done = 1'b0;
    end
    // New control levels after a falling edge, held until the next call
    task automatic drive(input logic run, input logic stop_n, input logic sleep_n);
        @(negedge clock);
        bus_clock_running = run;
        stop_clock_request_n = stop_n;
        sleep_request_n = sleep_n;
    endtask
    // Snoop held until serviced after a chosen delay
    task automatic snoop(input int delay);
        @(negedge clock);
        snoop_request = 1'b1;
        repeat (delay) @(negedge clock);
        snoop_done = 1'b1;
        @(negedge clock);
        snoop_done = 1'b0;
        snoop_request = 1'b0;
    endtask
endmodule

// file: tb/test_deep_sleep_clock_control.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("Error %0t %h %h", $time, (a), (b)); end end
module test_deep_sleep_clock_control;
    import sleep_ctl_pkg::*;
    localparam int         SETTLE = 20;
    localparam logic [4:0] VSEL   = 5'h15;
    logic            clock, rst, halt_request, interrupt_in, cache_clock, cache_clock_enable, snoop_enable;
    logic            bus_clock_running, stop_clock_request_n, sleep_request_n, snoop_request, snoop_done;
    logic            interrupt_take, intc_clock_may_stop, bus_quiet_violation;
    logic [4:0]      voltage_select_code;
    power_state_type power_state, exp_state, origin, back;
    int              bad_count, compares, takes, settle_n;
    deep_sleep_clock_control #(.SETTLE_CYCLES(SETTLE), .CACHE_DIVIDE(2), .VSEL_CODE(VSEL)) i_dut (
        .clock, .rst, .bus_clock_running, .stop_clock_request_n, .sleep_request_n, .halt_request,
        .interrupt_in, .snoop_request, .snoop_done, .power_state, .cache_clock, .cache_clock_enable,
        .snoop_enable, .interrupt_take, .intc_clock_may_stop, .bus_quiet_violation, .voltage_select_code);
    system_logic_model i_chip (.clock, .bus_clock_running, .stop_clock_request_n, .sleep_request_n,
        .snoop_request, .snoop_done);
    // Bus clock reference
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Reference sequencer
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            exp_state = st_normal;
            origin = st_normal;
        end else begin
            settle_n = (exp_state == st_settle) ? settle_n + 1 : 0;
            if (exp_state inside {st_normal, st_auto_halt}) origin = exp_state;
            if (exp_state inside {st_stop_grant, st_auto_halt}) back = exp_state;
            case (exp_state)
                st_normal: if (!stop_clock_request_n) exp_state = st_stop_grant;
                    else if (halt_request) exp_state = st_auto_halt;
                st_auto_halt: if (!stop_clock_request_n) exp_state = st_stop_grant;
                    else if (snoop_request) exp_state = st_halt_snoop;
                    else if (interrupt_in) exp_state = st_normal;
                st_stop_grant: if (stop_clock_request_n) exp_state = origin;
                    else if (!sleep_request_n) exp_state = st_sleep;
                    else if (snoop_request) exp_state = st_halt_snoop;
                st_halt_snoop: if (snoop_done) exp_state = back;
                st_sleep: if (!bus_clock_running) exp_state = st_deep_sleep;
                    else if (sleep_request_n) exp_state = st_stop_grant;
                st_deep_sleep: if (bus_clock_running) exp_state = st_settle;
                default: if (!bus_clock_running) exp_state = st_deep_sleep;
                    else if (settle_n == SETTLE + 1) exp_state = st_sleep;
            endcase
        end
    end
    // Compare with the reference between edges
    always @(negedge clock) begin
        if (interrupt_take === 1'b1) takes++;
        if (!rst) begin
            `CHK(power_state, exp_state)
            `CHK(cache_clock_enable, !(exp_state inside {st_deep_sleep, st_settle}))
            `CHK(snoop_enable, !(exp_state inside {st_sleep, st_deep_sleep, st_settle}))
            `CHK(intc_clock_may_stop, exp_state inside {st_sleep, st_deep_sleep})
            if (exp_state inside {st_deep_sleep, st_settle}) `CHK(cache_clock, 1'b0)
            `CHK(voltage_select_code, VSEL)
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Interrupt pulses one cycle apart
    task automatic irq(input int k);
        repeat (k) begin
            @(negedge clock);
            interrupt_in = 1'b1;
            @(negedge clock);
            interrupt_in = 1'b0;
        end
    endtask
    task automatic complete_run;
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        complete_run;
    end
    initial begin
        void'($urandom(32'h6a30));
        rst = 1'b1;
        halt_request = 1'b0;
        interrupt_in = 1'b0;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        irq(1);
        cyc(3);
        `CHK(takes, 1)
        // Stop-grant with held interrupts and a snoop
        takes = 0;
        i_chip.drive(1'b1, 1'b0, 1'b1);
        irq(2 + $urandom % 3);
        i_chip.snoop(1 + $urandom % 4);
        i_chip.drive(1'b1, 1'b1, 1'b1);
        cyc(5);
        `CHK(takes, 1)
        // Sleep request in normal is ignored
        i_chip.drive(1'b1, 1'b1, 1'b0);
        cyc(3);
        // Sleep, deep sleep, aborted then full settle
        takes = 0;
        i_chip.drive(1'b1, 1'b0, 1'b0);
        cyc(2);
        i_chip.drive(1'b0, 1'b0, 1'b0);
        irq(1);
        cyc(1);
        `CHK(bus_quiet_violation, 1'b1)
        i_chip.drive(1'b1, 1'b0, 1'b0);
        cyc(4);
        i_chip.drive(1'b0, 1'b0, 1'b0);
        cyc(3);
        i_chip.drive(1'b1, 1'b0, 1'b0);
        cyc(SETTLE + 4);
        i_chip.drive(1'b1, 1'b0, 1'b1);
        cyc(2);
        i_chip.drive(1'b1, 1'b1, 1'b1);
        cyc(4);
        `CHK(takes, 0)
        `CHK(bus_quiet_violation, 1'b0)
        // Halt with snoop and stop-clock, then back to auto-halt
        @(negedge clock);
        halt_request = 1'b1;
        @(negedge clock);
        halt_request = 1'b0;
        i_chip.snoop(2);
        i_chip.drive(1'b1, 1'b0, 1'b1);
        cyc(2);
        i_chip.drive(1'b1, 1'b1, 1'b0);
        cyc(3);
        // Interrupt wakes auto-halt and is then taken
        takes = 0;
        irq(1);
        cyc(3);
        `CHK(takes, 1)
        i_chip.drive(1'b1, 1'b1, 1'b1);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(4);
        complete_run;
    end
endmodule
bind deep_sleep_clock_control deep_sleep_clock_control_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_sva (
    .clock, .rst, .bus_clock_running, .stop_clock_request_n, .sleep_request_n, .snoop_request,
    .snoop_done, .power_state, .cache_clock, .cache_clock_enable, .snoop_enable, .interrupt_take);
